// ===== rtl/tcc_timer.v
// 16-bit free-running timer with two captures, two compares, Wishbone
// slave and byte-wide registers placed one per 32-bit word.
// Assumes a single CPU clock domain; capture and external clock pins are
// asynchronous and are synchronised here.
//
// How it works
// - Sixteen-bit up-counter read as high byte and low byte registers.
// - Writing either counter low byte reloads the counter with FFFCh.
// - Reset loads FFFCh; FFFCh is the only value ever reloaded.
// - Two-bit clock field selects CPU clock divided by 2, 4, 8 or external.
// - Both clock bits set picks external pin; edge bit picks transition.
// - External edges are resynchronised to the CPU clock before counting.
// - High byte read latches low byte until low byte is read.
// - After a complete sequence, lone low byte reads return live value.
// - Counter wrap from FFFFh to 0000h sets the overflow flag.
// - Overflow interrupt asserts when enabled and unmasked, else pends.
// - Overflow clears by status read then main low byte access only.
// - Wait mode ignored; halt stops counting and keeps the count.
// - Capture edge copies counter into capture register and sets flag.
// - Channel 1 edge bit in control 1, channel 2 edge bit in control 2.
// - One capture enable covers both flags, gated by global mask.
// - Capture flag clears by status read then capture low byte access.
// - Capture high byte read blocks captures and flag until low read.
// - In pulse or PWM mode only capture channel 2 captures.
// - Capture pins always feed the timer, even when driven as outputs.
// - Each timer tick compares both unsuppressed registers; match sets flag, and pin and irq when enabled.
// - Compare registers are software only and reset to 8000h.
// - On match with pin enabled, pin takes its level bit; reset low.
// - Compare flag clears by status read then compare low byte access.
// - Compare high byte write suppresses compares until low byte write.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_timer_regs.vh"

module tcc_timer
  (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        halt_i,
   input  wire        irq_mask_i,
   input  wire        ext_clock_pin_i,
   input  wire        capture_pin_1_i,
   input  wire        capture_pin_2_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         compare_pin_1_o,
   output reg         compare_pin_2_o,
   output reg         irq_o
   );

   reg [7:0]  ctrl1_r;
   reg [7:0]  ctrl2_r;
   reg [15:0] count_value_r;
   reg [7:0]  cnt_buf_r;
   reg        cnt_lock_r;
   reg [15:0] cap1_r;
   reg [15:0] cap2_r;
   reg [7:0]  cap1_buf_r;
   reg [7:0]  cap2_buf_r;
   reg        cap1_blk_r;
   reg        cap2_blk_r;
   reg [15:0] cmp1_r;
   reg [15:0] cmp2_r;
   reg        cmp1_blk_r;
   reg        cmp2_blk_r;
   reg        ovf_r;
   reg        capf1_r;
   reg        capf2_r;
   reg        cmpf1_r;
   reg        cmpf2_r;
   reg        ovf_arm_r;
   reg        capf1_arm_r;
   reg        capf2_arm_r;
   reg        cmpf1_arm_r;
   reg        cmpf2_arm_r;
   reg [2:0]  div_r;
   reg [2:0]  ext_sync_r;
   reg [2:0]  ic1_sync_r;
   reg [2:0]  ic2_sync_r;
   reg        ext_lvl_r;
   reg        ic1_lvl_r;
   reg        ic2_lvl_r;

   // Filtered level of a three-stage synchroniser: change once 2 and 3 agree.
   function filt;
      input [2:0] s;
      input       prev;
      begin
         filt = (s[2] == s[1]) ? s[1] : prev;
      end
   endfunction

   // Selected edge of a filtered level; sel high means rising.
   function edge_hit;
      input new_l;
      input old_l;
      input sel;
      begin
         edge_hit = sel ? (new_l & ~old_l) : (~new_l & old_l);
      end
   endfunction

   // Side effects land at the taking edge; ack and read data follow one
   // cycle later, so a master sees the new state as soon as it sees ack.
   wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [3:0] idx      = wb_adr_i[5:2];
   wire       wr       = req & wb_we_i & wb_sel_i[0];
   wire       rd       = req & ~wb_we_i;
   wire       acc      = wr | rd;
   wire       hit      = req & (idx != `TCC_OFS_NONE);

   wire       ext_new  = filt(ext_sync_r, ext_lvl_r);
   wire       ic1_new  = filt(ic1_sync_r, ic1_lvl_r);
   wire       ic2_new  = filt(ic2_sync_r, ic2_lvl_r);
   wire       special  = ctrl2_r[`TCC_C2_PULSE] | ctrl2_r[`TCC_C2_PWM];
   wire [1:0] clk_sel  = {ctrl2_r[`TCC_C2_CLK_HI], ctrl2_r[`TCC_C2_CLK_LO]};
   wire [2:0] div_mask = (clk_sel == 2'h0) ? `TCC_DIV4_MASK :
                         (clk_sel == 2'h1) ? `TCC_DIV2_MASK :
                         `TCC_DIV8_MASK;
   wire       ext_tick = edge_hit(ext_new, ext_lvl_r,
                                  ctrl2_r[`TCC_C2_EXT_EDGE]);
   // External edges are counted on the rising clock after the pin filter,
   // which keeps the whole block on a single clock edge.
   wire       tick     = ~halt_i & ((clk_sel == `TCC_CLK_EXT) ? ext_tick :
                         ((div_r & div_mask) == div_mask));
   wire       cap1_ev  = edge_hit(ic1_new, ic1_lvl_r,
                                  ctrl1_r[`TCC_C1_EDGE1]);
   wire       cap2_ev  = edge_hit(ic2_new, ic2_lvl_r,
                                  ctrl2_r[`TCC_C2_EDGE2]);
   wire       do_cap1  = cap1_ev & ~cap1_blk_r & ~special;
   wire       do_cap2  = cap2_ev & ~cap2_blk_r;
   wire       m1       = tick & ~cmp1_blk_r & (count_value_r == cmp1_r);
   wire       m2       = tick & ~cmp2_blk_r & (count_value_r == cmp2_r);
   wire       wrap     = tick & (count_value_r == `TCC_CNT_TOP);
   wire       st_rd    = rd & (idx == `TCC_OFS_STATUS);
   wire       cnt_lo   = acc & (idx == `TCC_OFS_CNT_LO);
   wire       acnt_lo  = acc & (idx == `TCC_OFS_ACNT_LO);
   wire       cnt_hi_rd = rd & ((idx == `TCC_OFS_CNT_HI) |
                                (idx == `TCC_OFS_ACNT_HI));
   wire       lo_rd    = rd & ((idx == `TCC_OFS_CNT_LO) |
                               (idx == `TCC_OFS_ACNT_LO));
   wire       cap1_lo  = acc & (idx == `TCC_OFS_CAP1_LO);
   wire       cap2_lo  = acc & (idx == `TCC_OFS_CAP2_LO);
   wire       cmp1_lo  = acc & (idx == `TCC_OFS_CMP1_LO);
   wire       cmp2_lo  = acc & (idx == `TCC_OFS_CMP2_LO);
   wire [7:0] status   = {capf1_r, cmpf1_r, ovf_r, capf2_r, cmpf2_r,
                          3'h0};

   reg [7:0]  rdata;
   always @*
   begin
      rdata = `TCC_BYTE_ZERO;
      if (idx == `TCC_OFS_CTRL1)
         rdata = ctrl1_r;
      else if (idx == `TCC_OFS_CTRL2)
         rdata = ctrl2_r;
      else if (idx == `TCC_OFS_STATUS)
         rdata = status;
      else if (idx == `TCC_OFS_CAP1_HI)
         rdata = cap1_r[15:8];
      else if (idx == `TCC_OFS_CAP1_LO)
         rdata = cap1_blk_r ? cap1_buf_r : cap1_r[7:0];
      else if (idx == `TCC_OFS_CAP2_HI)
         rdata = cap2_r[15:8];
      else if (idx == `TCC_OFS_CAP2_LO)
         rdata = cap2_blk_r ? cap2_buf_r : cap2_r[7:0];
      else if (idx == `TCC_OFS_CMP1_HI)
         rdata = cmp1_r[15:8];
      else if (idx == `TCC_OFS_CMP1_LO)
         rdata = cmp1_r[7:0];
      else if (idx == `TCC_OFS_CMP2_HI)
         rdata = cmp2_r[15:8];
      else if (idx == `TCC_OFS_CMP2_LO)
         rdata = cmp2_r[7:0];
      else if ((idx == `TCC_OFS_CNT_HI) || (idx == `TCC_OFS_ACNT_HI))
         rdata = count_value_r[15:8];
      else if ((idx == `TCC_OFS_CNT_LO) || (idx == `TCC_OFS_ACNT_LO))
         rdata = cnt_lock_r ? cnt_buf_r : count_value_r[7:0];
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl1_r       <= `TCC_BYTE_ZERO;
         ctrl2_r       <= `TCC_BYTE_ZERO;
         count_value_r <= `TCC_CNT_RELOAD;
         cnt_buf_r     <= `TCC_BYTE_ZERO;
         cnt_lock_r    <= 1'b0;
         cap1_r        <= `TCC_CAP_RESET;
         cap2_r        <= `TCC_CAP_RESET;
         cap1_buf_r    <= `TCC_BYTE_ZERO;
         cap2_buf_r    <= `TCC_BYTE_ZERO;
         cap1_blk_r    <= 1'b0;
         cap2_blk_r    <= 1'b0;
         cmp1_r        <= `TCC_CMP_RESET;
         cmp2_r        <= `TCC_CMP_RESET;
         cmp1_blk_r    <= 1'b0;
         cmp2_blk_r    <= 1'b0;
         ovf_r         <= 1'b0;
         capf1_r       <= 1'b0;
         capf2_r       <= 1'b0;
         cmpf1_r       <= 1'b0;
         cmpf2_r       <= 1'b0;
         ovf_arm_r     <= 1'b0;
         capf1_arm_r   <= 1'b0;
         capf2_arm_r   <= 1'b0;
         cmpf1_arm_r   <= 1'b0;
         cmpf2_arm_r   <= 1'b0;
         div_r         <= 3'h0;
         ext_sync_r    <= 3'h0;
         ic1_sync_r    <= 3'h0;
         ic2_sync_r    <= 3'h0;
         ext_lvl_r     <= 1'b0;
         ic1_lvl_r     <= 1'b0;
         ic2_lvl_r     <= 1'b0;
         compare_pin_1_o <= 1'b0;
         compare_pin_2_o <= 1'b0;
         irq_o         <= 1'b0;
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h00000000;
      end
      else if (ce_i)
      begin
         ext_sync_r <= {ext_sync_r[1:0], ext_clock_pin_i};
         ic1_sync_r <= {ic1_sync_r[1:0], capture_pin_1_i};
         ic2_sync_r <= {ic2_sync_r[1:0], capture_pin_2_i};
         ext_lvl_r  <= ext_new;
         ic1_lvl_r  <= ic1_new;
         ic2_lvl_r  <= ic2_new;
         wb_ack_o   <= req;
         wb_dat_o   <= {24'h000000, (hit ? rdata : `TCC_BYTE_ZERO)};

         if (wr && (idx == `TCC_OFS_CTRL1))
            ctrl1_r <= wb_dat_i[7:0];
         if (wr && (idx == `TCC_OFS_CTRL2))
            ctrl2_r <= wb_dat_i[7:0];

         if (~halt_i)
            div_r <= div_r + 3'h1;
         if (wr && ((idx == `TCC_OFS_CNT_LO) || (idx == `TCC_OFS_ACNT_LO)))
         begin
            count_value_r <= `TCC_CNT_RELOAD;
            div_r         <= 3'h0;
         end
         else if (tick)
            count_value_r <= count_value_r + 16'h0001;

         if (cnt_hi_rd && !cnt_lock_r)
         begin
            cnt_buf_r  <= count_value_r[7:0];
            cnt_lock_r <= 1'b1;
         end
         else if (lo_rd)
            cnt_lock_r <= 1'b0;

         // Arm on a status read that sees the flag; a status read that sees it clear
         // drops the arm, so only a low-byte access after an arming read completes the clear.
         if (st_rd)
         begin
            ovf_arm_r   <= ovf_r;
            capf1_arm_r <= capf1_r;
            capf2_arm_r <= capf2_r;
            cmpf1_arm_r <= cmpf1_r;
            cmpf2_arm_r <= cmpf2_r;
         end
         // Hardware set wins over a clear in the same cycle.
         if (wrap)
            ovf_r <= 1'b1;
         else if (cnt_lo && ovf_arm_r && !acnt_lo)
         begin
            ovf_r     <= 1'b0;
            ovf_arm_r <= 1'b0;
         end

         if (rd && (idx == `TCC_OFS_CAP1_HI))
         begin
            cap1_blk_r <= 1'b1;
            cap1_buf_r <= cap1_r[7:0];
         end
         else if (rd && (idx == `TCC_OFS_CAP1_LO))
            cap1_blk_r <= 1'b0;
         if (rd && (idx == `TCC_OFS_CAP2_HI))
         begin
            cap2_blk_r <= 1'b1;
            cap2_buf_r <= cap2_r[7:0];
         end
         else if (rd && (idx == `TCC_OFS_CAP2_LO))
            cap2_blk_r <= 1'b0;

         if (do_cap1)
         begin
            cap1_r  <= count_value_r;
            capf1_r <= 1'b1;
         end
         else if (cap1_lo && capf1_arm_r)
         begin
            capf1_r     <= 1'b0;
            capf1_arm_r <= 1'b0;
         end
         if (do_cap2)
         begin
            cap2_r  <= count_value_r;
            capf2_r <= 1'b1;
         end
         else if (cap2_lo && capf2_arm_r)
         begin
            capf2_r     <= 1'b0;
            capf2_arm_r <= 1'b0;
         end

         if (wr && (idx == `TCC_OFS_CMP1_HI))
         begin
            cmp1_r[15:8] <= wb_dat_i[7:0];
            cmp1_blk_r   <= 1'b1;
         end
         if (wr && (idx == `TCC_OFS_CMP1_LO))
         begin
            cmp1_r[7:0] <= wb_dat_i[7:0];
            cmp1_blk_r  <= 1'b0;
         end
         if (wr && (idx == `TCC_OFS_CMP2_HI))
         begin
            cmp2_r[15:8] <= wb_dat_i[7:0];
            cmp2_blk_r   <= 1'b1;
         end
         if (wr && (idx == `TCC_OFS_CMP2_LO))
         begin
            cmp2_r[7:0] <= wb_dat_i[7:0];
            cmp2_blk_r  <= 1'b0;
         end

         if (m1)
         begin
            cmpf1_r <= 1'b1;
            if (ctrl2_r[`TCC_C2_PIN1_EN])
               compare_pin_1_o <= ctrl1_r[`TCC_C1_LVL1];
         end
         else if (cmp1_lo && cmpf1_arm_r)
         begin
            cmpf1_r     <= 1'b0;
            cmpf1_arm_r <= 1'b0;
         end
         if (m2)
         begin
            cmpf2_r <= 1'b1;
            if (ctrl2_r[`TCC_C2_PIN2_EN])
               compare_pin_2_o <= ctrl1_r[`TCC_C1_LVL2];
         end
         else if (cmp2_lo && cmpf2_arm_r)
         begin
            cmpf2_r     <= 1'b0;
            cmpf2_arm_r <= 1'b0;
         end

         irq_o <= ~irq_mask_i &
                  ((ctrl1_r[`TCC_C1_OVF_IE] & ovf_r) |
                   (ctrl1_r[`TCC_C1_CAP_IE] & (capf1_r | capf2_r)) |
                   (ctrl1_r[`TCC_C1_CMP_IE] & (cmpf1_r | cmpf2_r)));
      end
   end

endmodule

// ===== rtl/tcc_timer_regs.vh
// Register offsets, field positions, reset values and timing constants
// for the 16-bit capture/compare timer.
// Assumes a Wishbone slave with byte-wide registers, one per word.
`ifndef TCC_TIMER_REGS_VH
`define TCC_TIMER_REGS_VH

`define TCC_OFS_CTRL1      4'h0
`define TCC_OFS_CTRL2      4'h1
`define TCC_OFS_STATUS     4'h2
`define TCC_OFS_CAP1_HI    4'h3
`define TCC_OFS_CAP1_LO    4'h4
`define TCC_OFS_CMP1_HI    4'h5
`define TCC_OFS_CMP1_LO    4'h6
`define TCC_OFS_CNT_HI     4'h7
`define TCC_OFS_CNT_LO     4'h8
`define TCC_OFS_ACNT_HI    4'h9
`define TCC_OFS_ACNT_LO    4'hA
`define TCC_OFS_CAP2_HI    4'hB
`define TCC_OFS_CAP2_LO    4'hC
`define TCC_OFS_CMP2_HI    4'hD
`define TCC_OFS_CMP2_LO    4'hE
`define TCC_OFS_NONE       4'hF

// Control 1 bits.
`define TCC_C1_CAP_IE      7
`define TCC_C1_CMP_IE      6
`define TCC_C1_OVF_IE      5
`define TCC_C1_LVL2        2
`define TCC_C1_EDGE1       1
`define TCC_C1_LVL1        0
// Control 2 bits.
`define TCC_C2_PIN1_EN     7
`define TCC_C2_PIN2_EN     6
`define TCC_C2_PULSE       5
`define TCC_C2_PWM         4
`define TCC_C2_CLK_HI      3
`define TCC_C2_CLK_LO      2
`define TCC_C2_EDGE2       1
`define TCC_C2_EXT_EDGE    0
// Status bits.
`define TCC_ST_CAP1        7
`define TCC_ST_CMP1        6
`define TCC_ST_OVF         5
`define TCC_ST_CAP2        4
`define TCC_ST_CMP2        3

`define TCC_CNT_RELOAD     16'hFFFC
`define TCC_CNT_TOP        16'hFFFF
`define TCC_CMP_RESET      16'h8000
`define TCC_CAP_RESET      16'h0000
`define TCC_CLK_EXT        2'h3
`define TCC_DIV2_MASK      3'h1
`define TCC_DIV4_MASK      3'h3
`define TCC_DIV8_MASK      3'h7
`define TCC_BYTE_ZERO      8'h00

`endif

// ===== bench/tcc_pin_model.sv
// Far-side pin model: external timer clock and both capture pins.
// Driven by the bench through its tasks; clk_i is the CPU clock.
`timescale 1ns/1ps
module tcc_pin_model
  (
   input  wire clk_i,
   output reg  ext_clock_pin_o,
   output reg  capture_pin_1_o,
   output reg  capture_pin_2_o
   );
   initial
   begin
      ext_clock_pin_o = 1'b0;
      capture_pin_1_o = 1'b0;
      capture_pin_2_o = 1'b0;
   end
   // Each active edge is at least eight CPU cycles after the last one.
   task ext_pulses(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            @(posedge clk_i) ext_clock_pin_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clock_pin_o <= 1'b0;
            repeat (4) @(posedge clk_i);
         end
      end
   endtask
   // Long levels so the pin filter accepts both transitions.
   task cap_pulse;
      begin
         @(posedge clk_i) capture_pin_1_o <= 1'b1;
         capture_pin_2_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         capture_pin_1_o <= 1'b0;
         capture_pin_2_o <= 1'b0;
         repeat (8) @(posedge clk_i);
      end
   endtask
endmodule

// ===== bench/tcc_timer_monitor.sv
// Port checker for the capture/compare timer.
// Bound to tcc_timer; sees only its ports, one clock domain.
`timescale 1ns/1ps
module tcc_timer_chk
  (
   input wire        clk_i,
   input wire        rst_i,
   input wire        ce_i,
   input wire        halt_i,
   input wire        irq_mask_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        compare_pin_1_o,
   input wire        compare_pin_2_o,
   input wire        irq_o
   );
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
      |=> wb_ack_o) else $error("ack missing one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o)
      |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_RST_PINS: assert property ($fell(rst_i) |-> !compare_pin_1_o
      && !compare_pin_2_o && !irq_o) else $error("outputs not low at reset");
   AST_IRQ_MASK: assert property (ce_i && irq_mask_i |=> !irq_o)
      else $error("irq raised while masked");
   AST_HALT_PIN1: assert property (halt_i [*3] |-> $stable(compare_pin_1_o))
      else $error("compare pin 1 moved while halted");
   AST_HALT_PIN2: assert property (halt_i [*3] |-> $stable(compare_pin_2_o))
      else $error("compare pin 2 moved while halted");
   cover property ($rose(irq_o));
   cover property ($rose(compare_pin_1_o));
   cover property ($rose(compare_pin_2_o));
endmodule
bind tcc_timer tcc_timer_chk u_tcc_timer_chk
  (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .halt_i(halt_i),
   .irq_mask_i(irq_mask_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .compare_pin_1_o(compare_pin_1_o), .compare_pin_2_o(compare_pin_2_o));

// ===== bench/tb.sv
// Self-checking bench for the capture/compare timer.
// Drives the Wishbone slave and the pin model; clock 40 MHz.
`timescale 1ns/1ps
module tb;
   reg         clk_i, rst_i, ce_i, halt_i, irq_mask_i;
   reg         cyc, stb, we;
   reg  [5:0]  adr;
   reg  [31:0] dat;
   wire [31:0] dat_o;
   wire        ack, pin1, pin2, irq, ext, cap1, cap2;
   integer     mismatches, n_checks, i;
   tcc_timer u_tcc_timer
     (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .halt_i(halt_i),
      .irq_mask_i(irq_mask_i), .ext_clock_pin_i(ext),
      .capture_pin_1_i(cap1), .capture_pin_2_i(cap2), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .compare_pin_1_o(pin1), .compare_pin_2_o(pin2), .irq_o(irq));
   tcc_pin_model u_tcc_pin_model
     (.clk_i(clk_i), .ext_clock_pin_o(ext), .capture_pin_1_o(cap1),
      .capture_pin_2_o(cap2));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task results;
      begin
         $display("checks %0d mismatches %0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e)
         begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // One classic cycle; ack and read data are taken at the rising edge
   // that samples ack high, and only then is the request released.
   task wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
           output logic [7:0] q);
      integer n;
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         stb <= 1'b1;
         we  <= w;
         adr <= {idx, 2'b00};
         dat <= {24'h000000, d};
         n = 0;
         @(posedge clk_i);
         while (ack !== 1'b1 && n < 20)
         begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (ack !== 1'b1)
         begin
            mismatches = mismatches + 1;
            results;
         end
         q = dat_o[7:0];
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask
   task rd(input logic [3:0] idx, input logic [7:0] e);
      logic [7:0] q;
      begin
         wb(1'b0, idx, 8'h00, q);
         chk($sformatf("reg%0h", idx), e, q);
      end
   endtask
   task t_reset;
      begin
         rd(4'h5, 8'h80);
         rd(4'h6, 8'h00);
         rd(4'hD, 8'h80);
         rd(4'h7, 8'hFF);
         rd(4'h8, 8'hFC);
         rd(4'h2, 8'h00);
         rd(4'hF, 8'h00);
      end
   endtask
   task t_capture;
      begin
         wr(4'h0, 8'h02);
         u_tcc_pin_model.cap_pulse;
         rd(4'h2, 8'h90);
         rd(4'h3, 8'hFF);
         rd(4'h4, 8'hFC);
         rd(4'hB, 8'hFF);
         rd(4'hC, 8'hFC);
         rd(4'h2, 8'h00);
         rd(4'h3, 8'hFF);
         halt_i <= 1'b0;
         repeat (8) @(posedge clk_i);
         halt_i <= 1'b1;
         u_tcc_pin_model.cap_pulse;
         rd(4'h2, 8'h10);
         rd(4'h4, 8'hFC);
         wr(4'hC, 8'h00);
      end
   endtask
   task t_clock;
      logic [7:0] ex [0:2];
      logic [1:0] cs [0:2];
      logic [7:0] q;
      begin
         ex[0] = 8'h1C;
         ex[1] = 8'h0C;
         ex[2] = 8'h04;
         cs[0] = 2'b01;
         cs[1] = 2'b00;
         cs[2] = 2'b10;
         for (i = 0; i < 3; i = i + 1)
         begin
            wr(4'h1, {4'h0, cs[i], 2'b00});
            wr(i == 2 ? 4'hA : 4'h8, 8'h55);
            halt_i <= 1'b0;
            repeat (64) @(posedge clk_i);
            halt_i <= 1'b1;
            wb(1'b0, 4'h8, 8'h00, q);
            chk("tick_lo", ex[i], q);
         end
      end
   endtask
   task t_ext;
      begin
         wr(4'h1, 8'h0D);
         halt_i <= 1'b0;
         wr(4'h8, 8'h00);
         u_tcc_pin_model.ext_pulses(5);
         rd(4'h7, 8'h00);
         rd(4'h8, 8'h01);
         rd(4'h2, 8'h20);
      end
   endtask
   task t_ovf;
      begin
         wr(4'h0, 8'h20);
         irq_mask_i <= 1'b0;
         repeat (3) @(posedge clk_i);
         chk("irq", 8'h01, {7'h00, irq});
         irq_mask_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         chk("irq", 8'h00, {7'h00, irq});
         rd(4'hA, 8'h01);
         rd(4'h2, 8'h20);
         rd(4'h8, 8'h01);
         rd(4'h2, 8'h00);
         rd(4'h7, 8'h00);
         u_tcc_pin_model.ext_pulses(2);
         rd(4'h7, 8'h00);
         rd(4'h8, 8'h01);
         rd(4'h8, 8'h03);
      end
   endtask
   task t_cmp;
      begin
         wr(4'h1, 8'hCD);
         wr(4'h0, 8'h05);
         wr(4'h5, 8'h00);
         wr(4'h6, 8'h05);
         wr(4'hD, 8'h00);
         wr(4'hE, 8'h06);
         wr(4'hD, 8'h00);
         u_tcc_pin_model.ext_pulses(4);
         chk("pin1", 8'h01, {7'h00, pin1});
         chk("pin2", 8'h00, {7'h00, pin2});
         wr(4'hE, 8'h09);
         u_tcc_pin_model.ext_pulses(4);
         chk("pin2", 8'h01, {7'h00, pin2});
         rd(4'h2, 8'h48);
         rd(4'h6, 8'h05);
      end
   endtask
   // Compare flag clears, pulse mode capture gating, capture interrupt.
   task t_modes;
      begin
         rd(4'h2, 8'h08);
         wr(4'hE, 8'h09);
         rd(4'h2, 8'h00);
         wr(4'h0, 8'h80);
         wr(4'h1, 8'h2D);
         irq_mask_i <= 1'b0;
         u_tcc_pin_model.cap_pulse;
         rd(4'h2, 8'h10);
         chk("irq", 8'h01, {7'h00, irq});
         rd(4'h3, 8'hFF);
         rd(4'h4, 8'hFC);
         rd(4'hB, 8'h00);
         rd(4'hC, 8'h0B);
         rd(4'h2, 8'h00);
         chk("irq", 8'h00, {7'h00, irq});
         irq_mask_i <= 1'b1;
      end
   endtask
   initial
   begin
      mismatches = 0;
      n_checks = 0;
      rst_i = 1'b1;
      ce_i = 1'b1;
      halt_i = 1'b1;
      irq_mask_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      dat = 32'h00000000;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_capture;
      t_clock;
      t_ext;
      t_ovf;
      t_cmp;
      t_modes;
      results;
   end
endmodule
